// ===== hw/counter_pkg.sv
/*
 * Shared constants and carriers of the three-counter timer block:
 * register offsets, control-byte fields, counting modes, reset values
 * and the fixed-rate tick divider.
 * Assumes a 40 MHz system clock and a byte-wide register view that
 * sits in the low byte of each 32-bit word.
 */
package counter_pkg;

	// ****************************************
	// clocking
	// ****************************************
	localparam int unsigned MCLK_HZ = 40_000_000;
	localparam int unsigned FIXED_HZ = 10_000_000;
	localparam int unsigned FIXED_DIV = MCLK_HZ / FIXED_HZ;
	localparam logic [1:0] FIXED_DIV_LAST = 2'(FIXED_DIV - 1);

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] CNT0_OFS = 8'h00;
	localparam logic [7:0] CNT1_OFS = 8'h04;
	localparam logic [7:0] CNT2_OFS = 8'h08;
	localparam logic [7:0] CTRL_OFS = 8'h0c;
	localparam logic [7:0] STAT_PEEK_OFS = 8'h10;
	localparam logic [7:0] STAT_CLR_OFS = 8'h14;

	// ****************************************
	// control byte fields
	// ****************************************
	localparam int CTRL_SEL_LO = 6;
	localparam int CTRL_ACC_LO = 4;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_BCD_BIT = 0;
	localparam logic [1:0] SEL_READBACK = 2'h3;

	localparam logic [1:0] ACC_LATCH = 2'h0;
	localparam logic [1:0] ACC_LSB = 2'h1;
	localparam logic [1:0] ACC_MSB = 2'h2;
	localparam logic [1:0] ACC_WORD = 2'h3;

	localparam logic [2:0] MODE_SW_ONESHOT = 3'h0;
	localparam logic [2:0] MODE_HW_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_STROBE = 3'h5;

	// one bit per mode number accepted by a counter
	localparam logic [7:0] CNT0_MODES = 8'h2a;
	localparam logic [7:0] CNT12_MODES = 8'h09;

	// ****************************************
	// status register fields
	// ****************************************
	localparam int STAT_EN_LO = 4;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [1:0] ACC_RST = ACC_WORD;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] EN_RST = 2'h0;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic [2:0] mode;
		logic [1:0] acc;
		logic bcd;
	} ctl_t;

endpackage

// ===== hw/triple_counter_timer_irq.sv
/*
 * Three 16-bit down counters with a timer interrupt status register.
 * Counter 0 counts edges of a backplane clock pin and is triggered by a
 * synchronised backplane gate; counters 1 and 2 count a 10 MHz tick.
 * Assumes a single 40 MHz clock, a synchronous active-high reset and a
 * register master that never waits.
 */
// The strobed register port was chosen for this implementation.
// What this block does
// RULE1 - each counter is an independent 16-bit down counter driving its output
// RULE2 - counters 1,2 tick at 10 MHz; counter 0 only from its clock pin
// RULE3 - counters 1,2 have gate always on; modes 1 and 5 refused
// RULE4 - gate pin fall is synchronised into one single-tick trigger pulse
// RULE5 - modes 0,3 on counters 1,2; modes 1,3,5 on counter 0
// RULE6 - mode 0: write drives output low; high after N+1 ticks
// RULE7 - mode 0: count rewritten mid-run loads on next tick
// RULE8 - mode 1: trigger loads count, output low n ticks, then high
// RULE9 - mode 1: a write does not disturb a running pulse; count reused
// RULE10 - mode 3: square wave of n ticks, high (n+1)/2, low n/2
// RULE11 - mode 3 on counter 0: gate trigger reloads and restarts
// RULE12 - mode 5: trigger starts delay; low pulse one tick after n+1
// RULE13 - rising output of counter 0 or 2 always sets its status bit
// RULE14 - request is status0 and enable4, or status1 and enable5
// RULE15 - read at clearing alias clears status; peek read leaves it
// RULE16 - enables take no data; each alias write toggles its own enable
// RULE17 - combined request drives module interrupt line until cleared
// RULE18 - counter 1 output goes straight to an edge-sensitive input
// RULE19 - counter 1,2 pins are active low; clock and gate pins too
// RULE20 - software should leave counter 0 unused on this revision
// RULE21 - status register is the low byte of two adjacent words
// RULE22 - access field picks latch, low, high or low-then-high bytes
// RULE23 - control bit 0 selects binary or BCD counting
// RULE24 - status bits 2,3,6,7 read zero and ignore writes
`timescale 1ns/1ps

module counter_unit #(
	parameter logic [7:0] MODES_OK = 8'h09,
	parameter logic [2:0] MODE_RST = 3'h0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// count timing
	input wire logic tick,
	input wire logic trig,
	// register access
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_byte,
	input wire logic data_wr,
	input wire logic data_rd,
	input wire logic [7:0] wbyte,
	output logic [7:0] rbyte,
	// output, active high
	output logic out_act
);
	import counter_pkg::*;

	logic [15:0] count_reg, count_next;
	logic [15:0] init_reg, init_next;
	logic [15:0] latch_reg, latch_next;
	logic latched_reg, latched_next;
	ctl_t ctl_reg, ctl_next;
	logic whi_reg, whi_next;
	logic rhi_reg, rhi_next;
	logic load_reg, load_next;
	logic run_reg, run_next;
	logic out_reg, out_next;
	logic done;
	logic [16:0] period;
	logic [15:0] hi_len;
	logic [15:0] lo_len;
	ctl_t ctl_in;

	// RULE23 bcd decrement
	function automatic logic [15:0] dec_count(input logic [15:0] v,
			input logic bcd);
		logic [15:0] r;
		logic borrow;
		r = v;
		borrow = 1'b1;
		if (!bcd) begin
			r = v - 16'h0001;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (borrow) begin
					if (v[i*4 +: 4] == 4'h0) begin
						r[i*4 +: 4] = 4'h9;
					end else begin
						r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
						borrow = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	function automatic logic [16:0] bcd_to_bin(input logic [15:0] v);
		return {13'h0, v[15:12]} * 17'h0_03e8 + {13'h0, v[11:8]} * 17'h0_0064
			+ {13'h0, v[7:4]} * 17'h0_000a + {13'h0, v[3:0]};
	endfunction

	assign ctl_in = '{mode: ctrl_byte[CTRL_MODE_LO +: 3],
		acc: ctrl_byte[CTRL_ACC_LO +: 2], bcd: ctrl_byte[CTRL_BCD_BIT]};
	// RULE22 a count is complete after its last byte
	assign done = data_wr && (ctl_reg.acc != ACC_WORD || whi_reg);
	// RULE10 phase lengths; square wave halves always count in binary
	assign period = ctl_reg.bcd ? bcd_to_bin(init_reg) : {1'b0, init_reg};
	assign hi_len = 16'((period + 17'h0_0001) >> 1);
	assign lo_len = 16'(period >> 1);
	// RULE22 byte select for readback
	assign rbyte = (ctl_reg.acc == ACC_MSB || (ctl_reg.acc == ACC_WORD
		&& rhi_reg)) ? (latched_reg ? latch_reg[15:8] : count_reg[15:8])
		: (latched_reg ? latch_reg[7:0] : count_reg[7:0]);
	assign out_act = out_reg;

	always_comb begin
		count_next = count_reg;
		init_next = init_reg;
		latch_next = latch_reg;
		latched_next = latched_reg;
		ctl_next = ctl_reg;
		whi_next = whi_reg;
		rhi_next = rhi_reg;
		load_next = load_reg;
		run_next = run_reg;
		out_next = out_reg;
		// RULE1 counting on each tick
		if (tick) begin
			case (ctl_reg.mode)
				MODE_SW_ONESHOT: begin
					// RULE7 pending count loads on the tick
					if (load_reg) begin
						count_next = init_reg;
						load_next = 1'b0;
					end else if (count_reg != 16'h0000) begin
						count_next = dec_count(count_reg, ctl_reg.bcd);
						// RULE6 output high at zero
						if (count_reg == 16'h0001) begin
							out_next = 1'b1;
						end
					end
				end
				MODE_HW_ONESHOT: begin
					// RULE8 trigger loads and drops output
					if (trig) begin
						count_next = init_reg;
						out_next = 1'b0;
						run_next = 1'b1;
					end else if (run_reg) begin
						count_next = dec_count(count_reg, ctl_reg.bcd);
						if (count_reg == 16'h0001) begin
							out_next = 1'b1;
							run_next = 1'b0;
						end
					end
				end
				MODE_SQUARE: begin
					// RULE11 gate trigger resynchronises
					if (load_reg || (trig && run_reg)) begin
						count_next = hi_len;
						out_next = 1'b1;
						load_next = 1'b0;
						run_next = 1'b1;
					end else if (run_reg) begin
						// RULE10 toggle at end of each half
						if (count_reg <= 16'h0001) begin
							out_next = !out_reg;
							count_next = out_reg ? lo_len : hi_len;
						end else begin
							count_next = count_reg - 16'h0001;
						end
					end
				end
				MODE_STROBE: begin
					if (!out_reg) begin
						out_next = 1'b1;
					end
					// RULE12 retrigger restarts the delay
					if (trig) begin
						count_next = init_reg;
						run_next = 1'b1;
					end else if (run_reg) begin
						if (count_reg == 16'h0000) begin
							out_next = 1'b0;
							run_next = 1'b0;
						end else begin
							count_next = dec_count(count_reg, ctl_reg.bcd);
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (ctrl_wr) begin
			if (ctl_in.acc == ACC_LATCH) begin
				// RULE22 freeze count for readback
				if (!latched_reg) begin
					latch_next = count_reg;
					latched_next = 1'b1;
				end
			// RULE3 unsupported modes leave the counter as it was
			end else if (MODES_OK[ctl_in.mode]) begin
				ctl_next = ctl_in;
				whi_next = 1'b0;
				rhi_next = 1'b0;
				out_next = 1'b1;
				run_next = 1'b0;
				load_next = 1'b0;
			end
		end
		if (data_wr) begin
			case (ctl_reg.acc)
				ACC_LSB: init_next = {8'h00, wbyte};
				ACC_MSB: init_next = {wbyte, 8'h00};
				default: begin
					if (whi_reg) begin
						init_next[15:8] = wbyte;
					end else begin
						init_next[7:0] = wbyte;
					end
					whi_next = !whi_reg;
				end
			endcase
		end
		// RULE9 modes 1 and 5 only store the count
		if (done && ctl_reg.mode == MODE_SW_ONESHOT) begin
			// RULE6 write drives output low
			out_next = 1'b0;
			load_next = 1'b1;
		end
		if (done && ctl_reg.mode == MODE_SQUARE) begin
			load_next = 1'b1;
		end
		if (data_rd) begin
			if (ctl_reg.acc == ACC_WORD) begin
				rhi_next = !rhi_reg;
			end
			if (ctl_reg.acc != ACC_WORD || rhi_reg) begin
				latched_next = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			count_reg <= COUNT_RST;
			init_reg <= COUNT_RST;
			latch_reg <= COUNT_RST;
			latched_reg <= 1'b0;
			ctl_reg <= '{mode: MODE_RST, acc: ACC_RST, bcd: 1'b0};
			whi_reg <= 1'b0;
			rhi_reg <= 1'b0;
			load_reg <= 1'b0;
			run_reg <= 1'b0;
			out_reg <= 1'b1;
		end else begin
			count_reg <= count_next;
			init_reg <= init_next;
			latch_reg <= latch_next;
			latched_reg <= latched_next;
			ctl_reg <= ctl_next;
			whi_reg <= whi_next;
			rhi_reg <= rhi_next;
			load_reg <= load_next;
			run_reg <= run_next;
			out_reg <= out_next;
		end
	end

	mode0_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE6
		(done && !ctrl_wr && ctl_reg.mode == MODE_SW_ONESHOT)
		|=> !out_reg && load_reg)
		else $error("mode 0 write did not drop output");
	mode1_trigger_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE8
		(tick && trig && !ctrl_wr && ctl_reg.mode == MODE_HW_ONESHOT)
		|=> !out_reg && count_reg == $past(init_reg))
		else $error("mode 1 trigger did not load count");
	mode_refused_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE3
		(ctrl_wr && ctl_in.acc != ACC_LATCH && !MODES_OK[ctl_in.mode])
		|=> ctl_reg == $past(ctl_reg))
		else $error("unsupported mode was accepted");
	strobe_width_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE12
		(tick && !out_reg && !ctrl_wr && ctl_reg.mode == MODE_STROBE)
		|=> out_reg)
		else $error("strobe low longer than one tick");
endmodule

module triple_counter_timer_irq (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register port
	input wire counter_pkg::bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	// backplane pins, active low
	input wire logic counter0_clock_in_n,
	input wire logic counter0_gate_in_n,
	output logic counter1_out_n,
	output logic counter2_out_n,
	// interrupt lines
	output logic counter1_irq_out,
	output logic timer_irq_out
);
	import counter_pkg::*;

	logic [1:0] div_reg, div_next;
	logic [2:0] ck_sync_reg, ck_sync_next;
	logic [2:0] gt_sync_reg, gt_sync_next;
	logic trig_reg, trig_next;
	logic [1:0] stat_reg, stat_next;
	logic [1:0] en_reg, en_next;
	logic [1:0] prev_reg, prev_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] pins_reg, pins_next;
	logic irq1_reg, irq1_next;
	logic tick_fixed, tick0, gate_fall;
	logic [2:0] out_act;
	logic [2:0] ctrl_hit, data_wr, data_rd;
	logic [7:0] rbyte [3];
	logic [1:0] rise;
	logic clr_rd;

	// RULE2 fixed 10 MHz tick from the system clock
	assign tick_fixed = (div_reg == FIXED_DIV_LAST);
	// RULE19 clock pin ticks counter 0 on its falling edge
	assign tick0 = ck_sync_reg[2] && !ck_sync_reg[1];
	// RULE4 gate pin high-to-low after two-stage sync
	assign gate_fall = gt_sync_reg[2] && !gt_sync_reg[1];

	generate
		for (genvar i = 0; i < 3; i++) begin : g_cnt
			assign ctrl_hit[i] = bus_req.wr && bus_req.addr == CTRL_OFS
				&& bus_req.wdata[CTRL_SEL_LO +: 2] == 2'(i);
			assign data_wr[i] = bus_req.wr
				&& bus_req.addr == CNT0_OFS + 8'(4 * i);
			assign data_rd[i] = bus_req.rd
				&& bus_req.addr == CNT0_OFS + 8'(4 * i);
			// RULE5 counter 0 takes gate modes, others take 0 and 3
			counter_unit #(
				.MODES_OK(i == 0 ? CNT0_MODES : CNT12_MODES),
				.MODE_RST(i == 0 ? MODE_HW_ONESHOT : MODE_SW_ONESHOT)
			) u_cnt (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.tick(i == 0 ? tick0 : tick_fixed),
				// RULE3 gates of counters 1 and 2 never trigger
				.trig(i == 0 ? trig_reg : 1'b0),
				.ctrl_wr(ctrl_hit[i]),
				.ctrl_byte(bus_req.wdata[7:0]),
				.data_wr(data_wr[i]),
				.data_rd(data_rd[i]),
				.wbyte(bus_req.wdata[7:0]),
				.rbyte(rbyte[i]),
				.out_act(out_act[i])
			);
		end
	endgenerate

	assign rise = {out_act[2] && !prev_reg[1], out_act[0] && !prev_reg[0]};
	assign clr_rd = bus_req.rd && bus_req.addr == STAT_CLR_OFS;

	always_comb begin
		div_next = tick_fixed ? 2'h0 : div_reg + 2'h1;
		ck_sync_next = {ck_sync_reg[1:0], counter0_clock_in_n};
		gt_sync_next = {gt_sync_reg[1:0], counter0_gate_in_n};
		// RULE4 one pulse per fall, held until counter 0 ticks
		trig_next = gate_fall || (trig_reg && !tick0);
		prev_next = {out_act[2], out_act[0]};
		// RULE15 clear at end of the read; a new expiry still wins
		stat_next = clr_rd ? STAT_RST : stat_reg;
		// RULE13 low-to-high output always sets status
		stat_next = stat_next | rise;
		// RULE16 each alias write toggles only its own enable
		en_next = en_reg;
		if (bus_req.wr && bus_req.addr == STAT_PEEK_OFS) begin
			en_next[0] = !en_reg[0];
		end
		if (bus_req.wr && bus_req.addr == STAT_CLR_OFS) begin
			en_next[1] = !en_reg[1];
		end
		// RULE19 pins drive the inverse of the active outputs
		pins_next = {!out_act[2], !out_act[1]};
		// RULE18 counter 1 straight to its own interrupt input
		irq1_next = out_act[1];
		rdata_next = 32'h0000_0000;
		if (bus_req.rd) begin
			case (bus_req.addr)
				CNT0_OFS: rdata_next = {24'h00_0000, rbyte[0]};
				CNT1_OFS: rdata_next = {24'h00_0000, rbyte[1]};
				CNT2_OFS: rdata_next = {24'h00_0000, rbyte[2]};
				// RULE21 status in the low byte of both words
				// RULE24 unused status bits read zero
				STAT_PEEK_OFS, STAT_CLR_OFS: rdata_next = {24'h00_0000,
					2'h0, en_reg, 2'h0, stat_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			div_reg <= 2'h0;
			ck_sync_reg <= 3'h7;
			gt_sync_reg <= 3'h7;
			trig_reg <= 1'b0;
			stat_reg <= STAT_RST;
			en_reg <= EN_RST;
			prev_reg <= 2'h3;
			rdata_reg <= 32'h0000_0000;
			pins_reg <= 2'h0;
			irq1_reg <= 1'b1;
		end else begin
			div_reg <= div_next;
			ck_sync_reg <= ck_sync_next;
			gt_sync_reg <= gt_sync_next;
			trig_reg <= trig_next;
			stat_reg <= stat_next;
			en_reg <= en_next;
			prev_reg <= prev_next;
			rdata_reg <= rdata_next;
			pins_reg <= pins_next;
			irq1_reg <= irq1_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign counter1_out_n = pins_reg[0];
	assign counter2_out_n = pins_reg[1];
	assign counter1_irq_out = irq1_reg;
	// RULE14 gated status onto the request
	// RULE17 held until the clearing read
	assign timer_irq_out = (stat_reg[0] && en_reg[0])
		|| (stat_reg[1] && en_reg[1]);

	fixed_tick_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2
		tick_fixed |=> !tick_fixed [*3] ##1 tick_fixed)
		else $error("fixed tick not every fourth clock");
	gate_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE4
		(trig_reg && tick0 && !gate_fall) |=> !trig_reg)
		else $error("gate pulse wider than one tick");
	status_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE13
		rise[0] |=> stat_reg[0])
		else $error("counter 0 expiry not recorded");
	clear_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE15
		(clr_rd && rise == 2'h0) |=> !timer_irq_out && stat_reg == 2'h0)
		else $error("clearing read left status set");
	peek_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE15
		(bus_req.rd && bus_req.addr == STAT_PEEK_OFS)
		|=> stat_reg == ($past(stat_reg) | $past(rise)))
		else $error("peek read changed status");
	enable_toggle_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE16
		(bus_req.wr && bus_req.addr == STAT_PEEK_OFS)
		|=> en_reg[0] != $past(en_reg[0]) && en_reg[1] == $past(en_reg[1]))
		else $error("peek write did not toggle enable 4 alone");
	irq_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE17
		(timer_irq_out && !clr_rd && !bus_req.wr) |=> timer_irq_out)
		else $error("request dropped without clearing read");
	unused_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE24
		(bus_req.rd && bus_req.addr == STAT_CLR_OFS)
		|=> bus_rdata[7:6] == 2'h0 && bus_rdata[3:2] == 2'h0)
		else $error("unused status bits read nonzero");
	pin_level_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE19
		1'b1 |=> counter2_out_n == !$past(out_act[2]))
		else $error("counter 2 pin not inverted output");
endmodule

// ===== dv/backplane_model.sv
/*
 * Far-side model: backplane clock and gate pins of counter 0 and the
 * edge-sensitive interrupt input fed by counter 1.
 * Assumes the bench drives run and fire by non-blocking assignment on
 * the rising edge of mclk.
 */
`timescale 1ns/1ps

module backplane_model (
	// clock
	input wire logic mclk,
	// bench requests
	input wire logic run,
	input wire logic fire,
	// backplane pins, active low
	output logic clock_n = 1'b1,
	output logic gate_n = 1'b1,
	// edge interrupt input
	input wire logic irq1_in,
	output int irq1_edges = 0
);
	int phase = 0;
	int gate_left = 0;
	logic irq1_prev = 1'b1;

	// ****************************************
	// pin drivers
	// ****************************************
	// slow active-low clock
	// 2.5 MHz, below the 3 MHz limit; stands high outside runs
	always @(posedge mclk) begin
		phase <= (phase + 1) % 16;
		clock_n <= !(run && phase < 8);
	end

	always @(posedge mclk) begin
		if (fire)
			gate_left <= 8;
		else if (gate_left > 0)
			gate_left <= gate_left - 1;
		gate_n <= !(fire || gate_left > 1);
	end

	// ****************************************
	// interrupt input
	// ****************************************
	// edge-sensitive input
	always @(posedge mclk) begin
		irq1_prev <= irq1_in;
		if (irq1_in && !irq1_prev)
			irq1_edges <= irq1_edges + 1;
	end
endmodule

// ===== dv/tb.sv
/*
 * Self-checking bench of the three-counter timer block.
 * Assumes the register port answers reads in the next cycle and the
 * backplane model stands on the counter 0 pins and the counter 1 interrupt line.
 */
`timescale 1ns/1ps

module tb;
	import counter_pkg::*;

	typedef struct {
		logic [7:0] ctrl;
		logic [7:0] lo;
		logic [7:0] hi;
		int hi_cyc;
		int lo_cyc;
	} sq_row_t;

	logic mclk;
	logic sys_rst;
	bus_req_t bus_req;
	logic [31:0] bus_rdata;
	logic counter0_clock_in_n;
	logic counter0_gate_in_n;
	logic counter1_out_n;
	logic counter2_out_n;
	logic counter1_irq_out;
	logic timer_irq_out;
	logic run;
	logic fire;
	int irq1_edges;
	int fail_count = 0;
	int comparisons = 0;
	int n;
	int e;
	logic [2:0] obs;
	// counter 1 mode 3 cases, in mclk cycles (tick every 4th)
	sq_row_t rows [6] = '{
		'{8'h66, 8'h00, 8'h01, 512, 512},
		'{8'h76, 8'h08, 8'h00, 16, 16},
		'{8'h56, 8'h05, 8'h00, 12, 8},
		'{8'h56, 8'h06, 8'h00, 12, 12},
		'{8'h56, 8'h07, 8'h00, 16, 12},
		'{8'h57, 8'h10, 8'h00, 20, 20}
	};

	assign obs = {timer_irq_out, counter2_out_n, counter1_irq_out};

	triple_counter_timer_irq triple_counter_timer_irq_inst (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.counter0_clock_in_n(counter0_clock_in_n),
		.counter0_gate_in_n(counter0_gate_in_n),
		.counter1_out_n(counter1_out_n),
		.counter2_out_n(counter2_out_n),
		.counter1_irq_out(counter1_irq_out),
		.timer_irq_out(timer_irq_out)
	);

	backplane_model backplane_model_inst (
		.mclk(mclk),
		.run(run),
		.fire(fire),
		.clock_n(counter0_clock_in_n),
		.gate_n(counter0_gate_in_n),
		.irq1_in(counter1_irq_out),
		.irq1_edges(irq1_edges)
	);

	// ****************************************
	// helpers
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = !mclk;
	end

	task automatic tally_and_finish();
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	function automatic logic [31:0] inr(input int v, input int lo,
		input int hi);
		return {31'h0000_0000, (v >= lo && v <= hi)};
	endfunction

	task automatic bw(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_req.addr <= a;
		bus_req.wdata <= {24'h00_0000, d};
		bus_req.wr <= 1'b1;
		@(posedge mclk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic st(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1;
		chk(bus_rdata, exp);
	endtask

	// cycles until an observed output reaches v; a hang ends the run
	task automatic wait_pin(input int which, input logic v, input int bound,
		output int cnt);
		cnt = 0;
		#1;
		while (obs[which] !== v) begin
			@(posedge mclk);
			#1;
			cnt++;
			if (cnt > bound) begin
				fail_count++;
				tally_and_finish();
			end
		end
	endtask

	task automatic pulse_gate();
		@(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
	endtask

	// program counter 0, clear status, trigger, cycles until request
	task automatic c0_run(input logic [7:0] ctrl, input int retrig,
		input logic [31:0] pre, output int cnt);
		bw(CTRL_OFS, ctrl);
		bw(CNT0_OFS, 8'h03);
		st(STAT_CLR_OFS, pre);
		repeat (64) @(posedge mclk);
		#1;
		chk(timer_irq_out, 1'b0);
		pulse_gate();
		if (retrig != 0) begin
			repeat (32) @(posedge mclk);
			pulse_gate();
		end
		wait_pin(2, 1'b1, 300, cnt);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		sys_rst = 1'b1;
		bus_req = '0;
		run = 1'b0;
		fire = 1'b0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			bw(CTRL_OFS, rows[i].ctrl);
			if (rows[i].ctrl[5:4] != ACC_MSB)
				bw(CNT1_OFS, rows[i].lo);
			if (rows[i].ctrl[5:4] != ACC_LSB)
				bw(CNT1_OFS, rows[i].hi);
			wait_pin(0, 1'b0, 1200, n);
			wait_pin(0, 1'b1, 1200, n);
			e = irq1_edges;
			chk(counter1_out_n, 1'b0);
			wait_pin(0, 1'b0, 1200, n);
			chk(n, rows[i].hi_cyc);
			wait_pin(0, 1'b1, 1200, n);
			chk(n, rows[i].lo_cyc);
			chk(irq1_edges - e, 1);
		end
		// mode 1 must be ignored by counter 1
		bw(CTRL_OFS, 8'h52);
		bw(CNT1_OFS, 8'h06);
		wait_pin(0, 1'b0, 100, n);
		wait_pin(0, 1'b1, 100, n);
		wait_pin(0, 1'b0, 100, n);
		chk(n, 12);
		// reset in mid-run
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk({counter1_out_n, counter2_out_n}, 2'b00);
		chk({counter1_irq_out, timer_irq_out}, 2'b10);
		@(posedge mclk);
		sys_rst <= 1'b0;
		st(STAT_PEEK_OFS, 32'h0000_0000);
		// counter 2 one-shot of 3, expiry status and enables
		bw(CTRL_OFS, 8'h90);
		bw(CNT2_OFS, 8'h03);
		wait_pin(1, 1'b1, 4, n);
		wait_pin(1, 1'b0, 30, e);
		chk(inr(n + e, 13, 18), 32'h0000_0001);
		repeat (4) @(posedge mclk);
		st(STAT_PEEK_OFS, 32'h0000_0002);
		chk(timer_irq_out, 1'b0);
		bw(STAT_CLR_OFS, 8'hff);
		#1;
		chk(timer_irq_out, 1'b1);
		st(STAT_PEEK_OFS, 32'h0000_0022);
		st(STAT_PEEK_OFS, 32'h0000_0022);
		st(STAT_CLR_OFS, 32'h0000_0022);
		st(STAT_PEEK_OFS, 32'h0000_0020);
		chk(timer_irq_out, 1'b0);
		bw(STAT_PEEK_OFS, 8'hff);
		st(STAT_PEEK_OFS, 32'h0000_0030);
		bw(STAT_PEEK_OFS, 8'h00);
		bw(STAT_CLR_OFS, 8'h00);
		st(STAT_PEEK_OFS, 32'h0000_0000);
		bw(8'h20, 8'hff);
		st(8'h20, 32'h0000_0000);
		st(STAT_CLR_OFS, 32'h0000_0000);
		// rewrite while counting restarts from the new value
		bw(CNT2_OFS, 8'h03);
		repeat (4) @(posedge mclk);
		bw(CNT2_OFS, 8'h0c);
		wait_pin(1, 1'b0, 100, n);
		chk(inr(n, 48, 56), 32'h0000_0001);
		// bcd count of 10, latched after one decrement, read low then high
		bw(CTRL_OFS, 8'hb1);
		bw(CNT2_OFS, 8'h10);
		bw(CNT2_OFS, 8'h00);
		repeat (6) @(posedge mclk);
		bw(CTRL_OFS, 8'h80);
		st(CNT2_OFS, 32'h0000_0009);
		st(CNT2_OFS, 32'h0000_0000);
		wait_pin(1, 1'b0, 100, n);
		chk(inr(n, 28, 32), 32'h0000_0001);
		// counter 0 used by the bench only
		run <= 1'b1;
		bw(STAT_PEEK_OFS, 8'h00);
		// counter 2 expiry still pending in status at the first clear
		c0_run(8'h1a, 0, 32'h0000_0012, n);
		chk(inr(n, 76, 112), 32'h0000_0001);
		c0_run(8'h12, 1, 32'h0000_0011, n);
		chk(inr(n, 44, 84), 32'h0000_0001);
		st(STAT_PEEK_OFS, 32'h0000_0011);
		tally_and_finish();
	end
endmodule
